// file: hdl/dssc_regs.svh
// Register offsets, field positions, reset values and latencies
`ifndef DSSC_REGS_SVH
`define DSSC_REGS_SVH

// ------------------------------------------------------------
// Register offsets (8-bit local microprocessor address space)
// ------------------------------------------------------------
`define DSSC_ADDR_IRQ_CLR      8'h66
`define DSSC_ADDR_IRQ_EN       8'h67
`define DSSC_ADDR_WRAP_LO      8'h68
`define DSSC_ADDR_WRAP_HI      8'h69
`define DSSC_ADDR_TARGET_LO    8'h6A
`define DSSC_ADDR_TARGET_HI    8'h6B
`define DSSC_ADDR_WANTED_LO    8'h6C
`define DSSC_ADDR_WANTED_HI    8'h6D
`define DSSC_ADDR_FINAL_LO     8'h6E
`define DSSC_ADDR_FINAL_HI     8'h6F
`define DSSC_ADDR_VECTOR       8'h72
`define DSSC_ADDR_SEQ          8'h73
`define DSSC_ADDR_LOOP         8'h74

// ------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------
`define DSSC_IRQ_MASK          8'hEF
`define DSSC_IRQ_HALTED_BIT    0
`define DSSC_IRQ_ROLLOVER_BIT  2
`define DSSC_SEQ_RUN_BIT       7
`define DSSC_SEC_HI_MASK       8'h03

// ------------------------------------------------------------
// Reset values and fixed codes
// ------------------------------------------------------------
`define DSSC_RST_BYTE          8'h00
`define DSSC_RST_SECTOR        10'h000
`define DSSC_RST_ADDR          5'h00
`define DSSC_STOP_ADDR         5'h1F

// ------------------------------------------------------------
// Start and stop latencies in byte clocks
// ------------------------------------------------------------
`define DSSC_START_LAT         3
`define DSSC_STOP_LAT          2

`endif

// file: hdl/dssc_pkg.sv
// Types shared by the disk sequencer sector control block
package dssc_pkg;

   // Sequencer run control states
   typedef enum logic [1:0] {
      DSSC_IDLE     = 2'b00,
      DSSC_STARTING = 2'b01,
      DSSC_RUNNING  = 2'b10,
      DSSC_STOPPING = 2'b11
   } dssc_run_t;

   typedef logic [9:0] dssc_sector_t;
   typedef logic [4:0] dssc_addr_t;
   typedef logic [7:0] dssc_byte_t;

endpackage

// file: hdl/dssc_sec_if.sv
// Carrier between the register bank and the wanted-sector counter
`timescale 1ns/1ps
interface dssc_sec_if;
   import dssc_pkg::*;
   logic         inc;
   logic         ld_lo;
   logic         ld_hi;
   dssc_byte_t   wdata;
   dssc_sector_t wrap_point;
   dssc_sector_t wrap_target;
   dssc_sector_t value;
   logic         wrapped;

   modport ctrl (output inc, ld_lo, ld_hi, wdata, wrap_point, wrap_target,
                 input value, wrapped);
   modport cnt  (input inc, ld_lo, ld_hi, wdata, wrap_point, wrap_target,
                 output value, wrapped);
endinterface

// file: hdl/dssc_sector_counter.sv
// Wanted-sector counter with wrap to the wrap target
`timescale 1ns/1ps
`include "dssc_regs.svh"
module dssc_sector_counter (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   // Link to the register bank
   dssc_sec_if.cnt   sec
);
   import dssc_pkg::*;

   dssc_sector_t value_r;
   logic         wrapped_r;
   dssc_sector_t value_nxt;
   logic         at_wrap;

   // ---------------------------------------------------------
   // Next value selection
   // ---------------------------------------------------------
   assign at_wrap = (value_r == sec.wrap_point);
   always_comb begin
      value_nxt = value_r;
      if (sec.ld_lo) begin
         value_nxt = {value_r[9:8], sec.wdata};
      end else if (sec.ld_hi) begin
         value_nxt = {sec.wdata[1:0], value_r[7:0]};
      end else if (sec.inc && at_wrap) begin
         value_nxt = sec.wrap_target;
      end else if (sec.inc) begin
         value_nxt = value_r + 10'h001;
      end
   end

   // Counter and wrap event register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         value_r   <= `DSSC_RST_SECTOR;
         wrapped_r <= 1'b0;
      end else begin
         value_r   <= value_nxt;
         wrapped_r <= sec.inc && at_wrap && !sec.ld_lo && !sec.ld_hi;
      end
   end

   assign sec.value   = value_r;
   assign sec.wrapped = wrapped_r;

   // Wrap loads the target instead of counting
   a_wrap_loads_target: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      (sec.inc && at_wrap && !sec.ld_lo && !sec.ld_hi)
      |=> (value_r == $past(sec.wrap_target)))
      else $error("wrap did not load target");
endmodule

// file: hdl/dssc_sector_ctrl.sv
// Disk sequencer sector control register bank
// ------------------------------------------------------------
// How it works
// - Writing ones clears matching status bits
// - Interrupt needs bit enable and group enable
// - Disabling a bit never alters its status
// - Set and enabled status raises active flag
// - Increment at wrap point loads wrap target
// - Ten-bit wrap target, two high bits kept
// - Flag when present sector equals wanted sector
// - Increment decode advances the wanted sector
// - End-of-transfer branch jumps when final equals wanted
// - Final sector commits on high byte write
// - Split zero branches to five-bit vector
// - Run start after three clocks, status immediate
// - Run clear stops within two to three clocks
// - Stopped address read returns last executed address other than the stop address
// - Loop write loads preload, read returns counter
// - Loop branch jumps on zero, else decrements
// - Status bits stay set until cleared
// - Running to stopped sets halted status
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "dssc_regs.svh"
module dssc_sector_ctrl (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   // Local microprocessor register port
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   input  wire dssc_pkg::dssc_byte_t  reg_addr_i,
   input  wire dssc_pkg::dssc_byte_t  reg_wdata_i,
   output      dssc_pkg::dssc_byte_t  reg_rdata_o,
   // Interrupt group control and summary
   input  wire logic                  disk_group_irq_master_enable_i,
   output      logic                  disk_irq_active_o,
   output      logic                  disk_irq_o,
   // Status events from the disk logic (bits 0, 2 and 4 unused)
   input  wire dssc_pkg::dssc_byte_t  status_event_i,
   // Sequencer decodes and state
   input  wire logic                  inc_wanted_i,
   input  wire logic                  eot_branch_i,
   input  wire logic                  loop_branch_i,
   input  wire logic                  split_zero_i,
   input  wire logic                  seq_exec_i,
   input  wire dssc_pkg::dssc_addr_t  seq_exec_addr_i,
   input  wire logic                  seq_halt_i,
   input  wire dssc_pkg::dssc_sector_t present_sector_i,
   // Sequencer control outputs
   output      logic                  seq_run_o,
   output      logic                  seq_start_o,
   output      dssc_pkg::dssc_addr_t  seq_start_addr_o,
   output      logic                  eot_jump_o,
   output      logic                  loop_jump_o,
   output      logic                  vector_jump_o,
   output      dssc_pkg::dssc_addr_t  vector_addr_o,
   output      logic                  present_matches_wanted_o,
   output      logic                  final_reached_o
);
   import dssc_pkg::*;

   // ---------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------
   dssc_sec_if sec ();

   dssc_byte_t   irq_status_r;
   dssc_byte_t   irq_enable_r;
   dssc_sector_t wrap_point_r;
   dssc_sector_t wrap_target_r;
   dssc_byte_t   final_lo_hold_r;
   dssc_sector_t final_sector_r;
   dssc_addr_t   vector_r;
   dssc_addr_t   start_addr_r;
   dssc_addr_t   last_addr_r;
   dssc_byte_t   loop_preload_r;
   dssc_byte_t   loop_count_r;
   dssc_run_t    run_state_r;
   dssc_run_t    run_state_nxt;
   logic [1:0]   lat_cnt_r;
   logic [1:0]   lat_cnt_nxt;
   dssc_byte_t   rdata_r;
   logic         irq_active_r;
   logic         irq_r;
   logic         seq_run_r;
   logic         seq_start_r;
   logic         eot_jump_r;
   logic         loop_jump_r;
   logic         vector_jump_r;
   logic         match_r;
   logic         final_eq_r;

   // ---------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------
   wire wr_clr     = reg_wr_i && (reg_addr_i == `DSSC_ADDR_IRQ_CLR);
   wire wr_en      = reg_wr_i && (reg_addr_i == `DSSC_ADDR_IRQ_EN);
   wire wr_wrap_lo = reg_wr_i && (reg_addr_i == `DSSC_ADDR_WRAP_LO);
   wire wr_wrap_hi = reg_wr_i && (reg_addr_i == `DSSC_ADDR_WRAP_HI);
   wire wr_tgt_lo  = reg_wr_i && (reg_addr_i == `DSSC_ADDR_TARGET_LO);
   wire wr_tgt_hi  = reg_wr_i && (reg_addr_i == `DSSC_ADDR_TARGET_HI);
   wire wr_want_lo = reg_wr_i && (reg_addr_i == `DSSC_ADDR_WANTED_LO);
   wire wr_want_hi = reg_wr_i && (reg_addr_i == `DSSC_ADDR_WANTED_HI);
   wire wr_fin_lo  = reg_wr_i && (reg_addr_i == `DSSC_ADDR_FINAL_LO);
   wire wr_fin_hi  = reg_wr_i && (reg_addr_i == `DSSC_ADDR_FINAL_HI);
   wire wr_vec     = reg_wr_i && (reg_addr_i == `DSSC_ADDR_VECTOR);
   wire wr_seq     = reg_wr_i && (reg_addr_i == `DSSC_ADDR_SEQ);
   wire wr_loop    = reg_wr_i && (reg_addr_i == `DSSC_ADDR_LOOP);

   // Run bit written as one or zero
   wire run_set    = wr_seq && reg_wdata_i[`DSSC_SEQ_RUN_BIT];
   wire run_clr    = wr_seq && !reg_wdata_i[`DSSC_SEQ_RUN_BIT];

   // ---------------------------------------------------------
   // Interrupt status, enables and summary
   // ---------------------------------------------------------
   wire seq_stopped_evt = (run_state_r == DSSC_RUNNING ||
                           run_state_r == DSSC_STOPPING) &&
                          (run_state_nxt == DSSC_IDLE);
   wire [7:0] set_vec = {status_event_i[7:5], 1'b0, status_event_i[3],
                         sec.wrapped, status_event_i[1],
                         seq_stopped_evt};
   wire [7:0] clr_vec = wr_clr ? (reg_wdata_i & `DSSC_IRQ_MASK)
                               : 8'h00;
   wire [7:0] status_nxt = ((irq_status_r & ~clr_vec) | set_vec) &
                           `DSSC_IRQ_MASK;
   wire [7:0] enable_nxt = wr_en ? (reg_wdata_i & `DSSC_IRQ_MASK)
                                 : irq_enable_r;
   wire       active_nxt = |(status_nxt & enable_nxt);

   // Status and enable registers, set wins over clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         irq_status_r <= `DSSC_RST_BYTE;
         irq_enable_r <= `DSSC_RST_BYTE;
      end else begin
         irq_status_r <= status_nxt;
         irq_enable_r <= enable_nxt;
      end
   end

   // Summary flag and gated interrupt
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         irq_active_r <= 1'b0;
         irq_r        <= 1'b0;
      end else begin
         irq_active_r <= active_nxt;
         irq_r <= active_nxt && disk_group_irq_master_enable_i;
      end
   end

   // ---------------------------------------------------------
   // Sector registers and wanted-sector counter
   // ---------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         wrap_point_r    <= `DSSC_RST_SECTOR;
         wrap_target_r   <= `DSSC_RST_SECTOR;
         final_lo_hold_r <= `DSSC_RST_BYTE;
         final_sector_r  <= `DSSC_RST_SECTOR;
         vector_r        <= `DSSC_RST_ADDR;
      end else begin
         if (wr_wrap_lo) wrap_point_r[7:0] <= reg_wdata_i;
         if (wr_wrap_hi) wrap_point_r[9:8] <= reg_wdata_i[1:0];
         if (wr_tgt_lo) wrap_target_r[7:0] <= reg_wdata_i;
         if (wr_tgt_hi) wrap_target_r[9:8] <= reg_wdata_i[1:0];
         if (wr_fin_lo) final_lo_hold_r <= reg_wdata_i;
         if (wr_fin_hi) begin
            final_sector_r <= {reg_wdata_i[1:0], final_lo_hold_r};
         end
         if (wr_vec) vector_r <= reg_wdata_i[4:0];
      end
   end

   // Wanted-sector counter; low-byte writes assume the run bit is clear
   assign sec.inc         = inc_wanted_i;
   assign sec.ld_lo       = wr_want_lo;
   assign sec.ld_hi       = wr_want_hi;
   assign sec.wdata       = reg_wdata_i;
   assign sec.wrap_point  = wrap_point_r;
   assign sec.wrap_target = wrap_target_r;

   dssc_sector_counter u_sector_counter (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .sec       (sec.cnt)
   );

   // ---------------------------------------------------------
   // Branch decisions for the sequencer
   // ---------------------------------------------------------
   wire want_eq_present = (sec.value == present_sector_i);
   wire want_eq_final   = (sec.value == final_sector_r);
   wire loop_zero       = (loop_count_r == 8'h00);

   // Registered jump pulses and compare flags
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         eot_jump_r    <= 1'b0;
         loop_jump_r   <= 1'b0;
         vector_jump_r <= 1'b0;
         match_r       <= 1'b0;
         final_eq_r    <= 1'b0;
      end else begin
         eot_jump_r    <= eot_branch_i && want_eq_final;
         loop_jump_r   <= loop_branch_i && loop_zero;
         vector_jump_r <= split_zero_i;
         match_r       <= want_eq_present;
         final_eq_r    <= want_eq_final;
      end
   end

   // Loop counter with separate preload
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         loop_preload_r <= `DSSC_RST_BYTE;
         loop_count_r   <= `DSSC_RST_BYTE;
      end else begin
         if (wr_loop) begin
            loop_preload_r <= reg_wdata_i;
            loop_count_r   <= reg_wdata_i;
         end else if (loop_branch_i && loop_zero) begin
            loop_count_r <= loop_preload_r;
         end else if (loop_branch_i) begin
            loop_count_r <= loop_count_r - 8'h01;
         end
      end
   end

   // ---------------------------------------------------------
   // Run control: start and stop latencies
   // ---------------------------------------------------------
   wire lat_done_start = (lat_cnt_r == 2'(`DSSC_START_LAT - 1));
   wire lat_done_stop  = (lat_cnt_r == 2'(`DSSC_STOP_LAT - 1));

   always_comb begin
      run_state_nxt = run_state_r;
      lat_cnt_nxt   = 2'b00;
      case (run_state_r)
         DSSC_IDLE: begin
            if (run_set) begin
               run_state_nxt = DSSC_STARTING;
            end
         end
         DSSC_STARTING: begin
            if (run_clr) begin
               run_state_nxt = DSSC_IDLE;
            end else if (lat_done_start) begin
               run_state_nxt = DSSC_RUNNING;
            end else begin
               lat_cnt_nxt = lat_cnt_r + 2'b01;
            end
         end
         DSSC_RUNNING: begin
            if (run_clr) begin
               run_state_nxt = DSSC_STOPPING;
            end else if (seq_halt_i) begin
               run_state_nxt = DSSC_IDLE;
            end
         end
         DSSC_STOPPING: begin
            if (lat_done_stop || seq_halt_i) begin
               run_state_nxt = DSSC_IDLE;
            end else begin
               lat_cnt_nxt = lat_cnt_r + 2'b01;
            end
         end
         default: run_state_nxt = DSSC_IDLE;
      endcase
   end

   // Run state, start pulse and address tracking
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         run_state_r  <= DSSC_IDLE;
         lat_cnt_r    <= 2'b00;
         seq_run_r    <= 1'b0;
         seq_start_r  <= 1'b0;
         start_addr_r <= `DSSC_RST_ADDR;
         last_addr_r  <= `DSSC_RST_ADDR;
      end else begin
         run_state_r <= run_state_nxt;
         lat_cnt_r   <= lat_cnt_nxt;
         seq_run_r   <= (run_state_nxt == DSSC_RUNNING) ||
                        (run_state_nxt == DSSC_STOPPING);
         seq_start_r <= (run_state_r == DSSC_STARTING) &&
                        (run_state_nxt == DSSC_RUNNING);
         if (run_set && run_state_r == DSSC_IDLE) begin
            start_addr_r <= reg_wdata_i[4:0];
         end
         if (seq_exec_i && seq_exec_addr_i != `DSSC_STOP_ADDR) begin
            last_addr_r <= seq_exec_addr_i;
         end
      end
   end

   // ---------------------------------------------------------
   // Read data
   // ---------------------------------------------------------
   wire        run_status = (run_state_r != DSSC_IDLE);
   wire [4:0]  addr_view  = run_status ? start_addr_r : last_addr_r;
   wire [7:0]  rd_mux =
      (reg_addr_i == `DSSC_ADDR_IRQ_CLR)    ? irq_status_r :
      (reg_addr_i == `DSSC_ADDR_IRQ_EN)     ? irq_enable_r :
      (reg_addr_i == `DSSC_ADDR_WRAP_LO)    ? wrap_point_r[7:0] :
      (reg_addr_i == `DSSC_ADDR_WRAP_HI)    ? {6'h00, wrap_point_r[9:8]} :
      (reg_addr_i == `DSSC_ADDR_TARGET_LO)  ? wrap_target_r[7:0] :
      (reg_addr_i == `DSSC_ADDR_TARGET_HI)  ? {6'h00, wrap_target_r[9:8]} :
      (reg_addr_i == `DSSC_ADDR_WANTED_LO)  ? sec.value[7:0] :
      (reg_addr_i == `DSSC_ADDR_WANTED_HI)  ? {6'h00, sec.value[9:8]} :
      (reg_addr_i == `DSSC_ADDR_FINAL_LO)   ? final_sector_r[7:0] :
      (reg_addr_i == `DSSC_ADDR_FINAL_HI)   ? {6'h00, final_sector_r[9:8]} :
      (reg_addr_i == `DSSC_ADDR_VECTOR)     ? {3'h0, vector_r} :
      (reg_addr_i == `DSSC_ADDR_SEQ)        ? {run_status, 2'h0, addr_view} :
      (reg_addr_i == `DSSC_ADDR_LOOP)       ? loop_count_r :
      8'h00;

   // Read data register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= `DSSC_RST_BYTE;
      end else if (reg_rd_i) begin
         rdata_r <= rd_mux;
      end
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   assign reg_rdata_o              = rdata_r;
   assign disk_irq_active_o        = irq_active_r;
   assign disk_irq_o               = irq_r;
   assign seq_run_o                = seq_run_r;
   assign seq_start_o              = seq_start_r;
   assign seq_start_addr_o         = start_addr_r;
   assign eot_jump_o               = eot_jump_r;
   assign loop_jump_o              = loop_jump_r;
   assign vector_jump_o            = vector_jump_r;
   assign vector_addr_o            = vector_r;
   assign present_matches_wanted_o = match_r;
   assign final_reached_o          = final_eq_r;

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_clear_drops_bit: assert property (
      (wr_clr && reg_wdata_i[5] && !status_event_i[5])
      |=> !irq_status_r[5])
      else $error("clear write left status bit set");

   a_irq_needs_master: assert property (
      disk_irq_o |-> $past(disk_group_irq_master_enable_i))
      else $error("interrupt without group enable");

   a_enable_keeps_status: assert property (
      (wr_en && !wr_clr) |=> (irq_status_r & ~$past(set_vec))
                           == ($past(irq_status_r) & ~$past(set_vec)))
      else $error("enable write changed status");

   a_active_summary: assert property (
      ##1 (disk_irq_active_o == |(irq_status_r & irq_enable_r)))
      else $error("active flag does not follow status");

   a_start_latency: assert property (
      (run_set && run_state_r == DSSC_IDLE) ##1 !run_clr [*3]
      |=> seq_start_o && seq_run_o)
      else $error("sequencer start not after three clocks");

   a_stop_latency: assert property (
      (run_clr && run_state_r == DSSC_RUNNING) |-> ##[2:3] !seq_run_o)
      else $error("sequencer stop not within three clocks");

   a_halted_sets: assert property (
      seq_stopped_evt |=> irq_status_r[`DSSC_IRQ_HALTED_BIT])
      else $error("halted status not set on stop");

   a_loop_reload: assert property (
      (loop_branch_i && loop_zero && !wr_loop)
      |=> loop_jump_o && loop_count_r == $past(loop_preload_r))
      else $error("loop branch did not reload");

   a_final_commit: assert property (
      wr_fin_lo |=> final_sector_r == $past(final_sector_r))
      else $error("final sector changed on low byte write");

   a_status_sticky: assert property (
      (irq_status_r[3] && !wr_clr) |=> irq_status_r[3])
      else $error("status bit dropped without clear");
endmodule

// file: dv/dssc_cpu_model.sv
// Local microprocessor model that drives the register port
`timescale 1ns/1ps
module dssc_cpu_model (
   // Clock and read data
   input  wire logic                 sys_clk_i,
   input  wire dssc_pkg::dssc_byte_t reg_rdata_i,
   // Register strobes, address and data
   output      logic                 reg_wr_o,
   output      logic                 reg_rd_o,
   output      dssc_pkg::dssc_byte_t reg_addr_o,
   output      dssc_pkg::dssc_byte_t reg_wdata_o
);
   import dssc_pkg::*;
   // Bus idle from time zero
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // One-cycle write; wanted low byte only written when stopped
   task automatic wr(input dssc_byte_t a, input dssc_byte_t d);
      @(posedge sys_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o    <= 1'b0;
   endtask
   // One-cycle read, data taken once the registered answer lands
   task automatic rd(input dssc_byte_t a, output dssc_byte_t d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_o   <= 1'b0;
      #1 d = reg_rdata_i;
   endtask
endmodule

// file: dv/tb_dssc_sector_ctrl.sv
// Self-checking bench for the sector control register bank
`timescale 1ns/1ps
module tb_dssc_sector_ctrl;
   import dssc_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, grp = 1'b0;
   logic [7:0] ev = 8'h00, d;
   logic [3:0] pls = 4'h0;
   logic [9:0] cur = 10'h001;
   logic       xe = 1'b0;
   logic [4:0] xa = 5'h0A;
   int         fails = 0, tests_run = 0, i;
   wire        wr, rd, act, irq, run, st, ej, lj, vj, pm, fr;
   dssc_byte_t adr, wd, rdat;
   dssc_addr_t sa, va;
   // Clock, 8 ns period
   initial forever #4 clk = ~clk;
   dssc_cpu_model cpu (.sys_clk_i(clk), .reg_rdata_i(rdat),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(adr), .reg_wdata_o(wd));
   dssc_sector_ctrl dut (.sys_clk_i(clk), .rst_n_i(rst_n),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(adr), .reg_wdata_i(wd),
      .reg_rdata_o(rdat), .disk_group_irq_master_enable_i(grp),
      .disk_irq_active_o(act), .disk_irq_o(irq), .status_event_i(ev),
      .inc_wanted_i(pls[0]), .eot_branch_i(pls[1]),
      .loop_branch_i(pls[2]), .split_zero_i(pls[3]), .seq_exec_i(xe),
      .seq_exec_addr_i(xa), .seq_halt_i(1'b0), .present_sector_i(cur),
      .seq_run_o(run), .seq_start_o(st), .seq_start_addr_o(sa),
      .eot_jump_o(ej), .loop_jump_o(lj), .vector_jump_o(vj),
      .vector_addr_o(va), .present_matches_wanted_o(pm),
      .final_reached_o(fr));
   // Compare and count
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle decode pulse, outputs settled one edge later
   task automatic pulse(input logic [3:0] p);
      @(posedge clk) pls <= p;
      @(posedge clk) pls <= 4'h0;
      #1;
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Status set, mask, group enable and clear
   task automatic t_status;
      cpu.wr(8'h67, 8'h20);
      @(posedge clk) ev <= 8'h20;
      @(posedge clk) ev <= 8'h00;
      repeat (3) @(posedge clk);
      chk(act, 1); chk(irq, 0);
      grp <= 1'b1;
      repeat (3) @(posedge clk);
      chk(irq, 1);
      cpu.wr(8'h67, 8'h00);
      cpu.rd(8'h66, d); chk(d, 8'h20); chk(act, 0);
      cpu.wr(8'h66, 8'h10); cpu.rd(8'h66, d); chk(d, 8'h20);
      cpu.wr(8'h66, 8'h20); cpu.rd(8'h66, d); chk(d, 8'h00);
   endtask
   // Wrap on increment, compare flags, staged final sector
   task automatic t_sector;
      cpu.wr(8'h68, 8'h05); cpu.wr(8'h69, 8'hFF);
      cpu.rd(8'h69, d); chk(d, 8'h03);
      cpu.wr(8'h6A, 8'h01); cpu.wr(8'h6B, 8'h00);
      cpu.wr(8'h6D, 8'h03); cpu.wr(8'h6C, 8'h05);
      pulse(4'h1);
      cpu.rd(8'h6C, d); chk(d, 8'h01);
      cpu.rd(8'h6D, d); chk(d, 8'h00);
      cpu.rd(8'h66, d); chk(d, 8'h04); chk(pm, 1);
      cpu.wr(8'h6E, 8'h01); pulse(4'h2); chk(ej, 0); chk(fr, 0);
      cpu.wr(8'h6F, 8'h00); pulse(4'h2); chk(ej, 1); chk(fr, 1);
   endtask
   // Loop counter preload and branch, vector branch
   task automatic t_loop;
      cpu.wr(8'h74, 8'h01); pulse(4'h4); chk(lj, 0);
      cpu.rd(8'h74, d); chk(d, 8'h00);
      pulse(4'h4); chk(lj, 1);
      cpu.rd(8'h74, d); chk(d, 8'h01);
      cpu.wr(8'h72, 8'hFF); cpu.rd(8'h72, d); chk(d, 8'h1F);
      pulse(4'h8); chk(vj, 1); chk(va, 5'h1F);
   endtask
   // Start latency, run status, stop latency and halted status
   task automatic t_run;
      cpu.wr(8'h73, 8'h85);
      for (i = 0; i < 4 && st !== 1'b1; i++) @(posedge clk) #1;
      chk(st, 1); chk(sa, 5'h05); chk(run, 1);
      chk(10'(i), 10'h003);
      cpu.rd(8'h73, d); chk(d, 8'h85);
      // Executed address 0Ah is kept, the stop address is not
      @(posedge clk) xe <= 1'b1;
      @(posedge clk) xa <= 5'h1F;
      @(posedge clk) xe <= 1'b0;
      cpu.wr(8'h73, 8'h00);
      #1 chk(run, 1);
      repeat (3) @(posedge clk);
      #1 chk(run, 0);
      cpu.rd(8'h66, d); chk(d, 8'h05);
      cpu.rd(8'h73, d); chk(d, 8'h0A);
   endtask
   // Watchdog
   initial begin
      #40000;
      fails++;
      stop_test();
   end
   // Reset for 4 cycles, then the scenarios
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_status(); t_sector(); t_loop(); t_run();
      stop_test();
   end
endmodule
